/* File: rtl/sem_mode_ctrl.sv */
// Purpose: single-ended clock/strobe mode control inside the memory device
// Assumes: command decoder delivers mode register writes/reads and burst commands
// Notes:   two set point copies of the mode register; active copy follows the set point
// Function
// [R1] host enables single-ended only at or below 800 MHz
// [R2] host leaves all termination off in single-ended use
// [R3] capability register bit 5 reports support
// [R4] all eight enable combinations accepted independently
// [R5] strobe mode covers reads, writes and equivalents
// [R6] read calibration ignores preamble training bit
// [R7] bit 1 selects read strobe mode
// [R8] bit 2 write strobe; single-ended forces strobe termination off
// [R9] bit 3 clock; single-ended forces clock termination off
// [R10] single-ended read: complement strobe only low or released
// [R11] host holds complement write strobe at valid level
// [R12] host keeps data reference code at or below 110010b
// [R13] host holds complement strobe high around bus training
// [R14] host holds complement clock at valid level
// [R15] host keeps command reference code at or below 110010b
// [R16] extra period after set point or high-current change; code waits on high-current entry only, not on exit
// [R17] read strobe bit writable any time
// [R18] host changes clock/write modes via set point switch
// [R19] two copies, active one selected by set point
// [R20] read strobe mode held for whole burst
`timescale 1ns/1ps

module sem_mode_ctrl
   import sem_pkg::*;
#(
   parameter bit SE_SUPPORTED = 1'b1
)
(
   input  wire logic     clock,
   input  wire logic     rst_n,
   input  wire sem_mrw_s mrw,
   input  wire logic [5:0] mrr_addr,
   input  wire logic     cmd_valid,
   input  wire sem_cmd_e cmd,
   input  wire logic     burst_active,
   input  wire logic     dqs_c_drive,
   input  wire logic     odt_ck_req,
   input  wire logic     odt_dq_req,
   output logic [7:0]    mrr_data,
   output sem_mode_s     active_mode,
   output logic          rd_burst_se,
   output logic          wr_burst_se,
   output logic          dqs_c_out,
   output logic          dqs_c_oe_n,
   output logic          odt_ck_en,
   output logic          odt_dq_en,
   output logic          se_ck_any,
   output logic          mrw_pst_busy
);

   // ----------------------------------------
   // mode registers
   // ----------------------------------------
   logic [7:0] se_ctrl [2];
   logic [7:0] next_se_ctrl [2];
   logic [7:0] fsp_ctrl;
   logic [7:0] next_fsp_ctrl;
   logic       wsel;
   logic       osel;

   assign wsel = fsp_ctrl[SEM_FSP_WR_BIT];
   assign osel = fsp_ctrl[SEM_FSP_OP_BIT];

   always_comb
   begin
      next_se_ctrl[0] = se_ctrl[0];
      next_se_ctrl[1] = se_ctrl[1];
      next_fsp_ctrl   = fsp_ctrl;
      if (mrw.valid && mrw.addr == SEM_ADDR_SE_CTRL)
      begin
         // every combination of bits 3..1 is stored as written
         next_se_ctrl[wsel] = mrw.data & 8'h0e; // R4 R19
         // read strobe bit takes effect in the active copy at once
         next_se_ctrl[osel][SEM_SE_RD_BIT] = mrw.data[SEM_SE_RD_BIT]; // R17
      end
      if (mrw.valid && mrw.addr == SEM_ADDR_FSP_CTRL)
      begin
         next_fsp_ctrl = mrw.data;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         se_ctrl[0] <= SEM_SE_CTRL_RST;
         se_ctrl[1] <= SEM_SE_CTRL_RST;
         fsp_ctrl   <= SEM_FSP_CTRL_RST;
      end
      else
      begin
         se_ctrl[0] <= next_se_ctrl[0];
         se_ctrl[1] <= next_se_ctrl[1];
         fsp_ctrl   <= next_fsp_ctrl;
      end
   end

   // ----------------------------------------
   // active mode and termination
   // ----------------------------------------
   always_comb
   begin
      active_mode.rd_se = se_ctrl[osel][SEM_SE_RD_BIT]; // R7 R19
      active_mode.wr_se = se_ctrl[osel][SEM_SE_WR_BIT]; // R8 R19
      active_mode.ck_se = se_ctrl[osel][SEM_SE_CK_BIT]; // R9 R19
   end

   assign odt_dq_en = odt_dq_req && !active_mode.wr_se; // R8
   assign odt_ck_en = odt_ck_req && !active_mode.ck_se; // R9
   assign se_ck_any = se_ctrl[0][SEM_SE_CK_BIT] || se_ctrl[1][SEM_SE_CK_BIT]; // R16

   // ----------------------------------------
   // mode register read data
   // ----------------------------------------
   logic [7:0] next_mrr_data;

   always_comb
   begin
      case (mrr_addr)
         SEM_ADDR_CAPABILITY:
         begin
            next_mrr_data = SEM_CAP_RST;
            next_mrr_data[SEM_CAP_SE_BIT] = SE_SUPPORTED; // R3
         end
         SEM_ADDR_SE_CTRL: next_mrr_data = se_ctrl[wsel];
         SEM_ADDR_FSP_CTRL: next_mrr_data = fsp_ctrl;
         default: next_mrr_data = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         mrr_data <= 8'h00;
      else
         mrr_data <= next_mrr_data;
   end

   // ----------------------------------------
   // per-burst strobe mode latch
   // ----------------------------------------
   logic is_rd;
   logic is_wr;
   logic next_rd_burst_se;
   logic next_wr_burst_se;

   always_comb
   begin
      // calibration reads follow the strobe mode regardless of preamble training
      case (cmd)
         SEM_CMD_READ, SEM_CMD_MRR, SEM_CMD_RD_FIFO, SEM_CMD_RD_DQ_CAL:
         begin
            is_rd = 1'b1; // R5 R6
            is_wr = 1'b0;
         end
         SEM_CMD_WRITE, SEM_CMD_MASK_WRITE, SEM_CMD_WR_FIFO:
         begin
            is_rd = 1'b0;
            is_wr = 1'b1; // R5
         end
         default:
         begin
            is_rd = 1'b0;
            is_wr = 1'b0;
         end
      endcase
      next_rd_burst_se = rd_burst_se;
      next_wr_burst_se = wr_burst_se;
      if (cmd_valid && is_rd)
         next_rd_burst_se = active_mode.rd_se; // R20
      if (cmd_valid && is_wr)
         next_wr_burst_se = active_mode.wr_se;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_burst_se <= 1'b0;
         wr_burst_se <= 1'b0;
      end
      else
      begin
         rd_burst_se <= next_rd_burst_se;
         wr_burst_se <= next_wr_burst_se;
      end
   end

   // ----------------------------------------
   // complement read strobe pin
   // ----------------------------------------
   always_comb
   begin
      if (rd_burst_se)
      begin
         dqs_c_out  = 1'b0; // R10
         dqs_c_oe_n = !(burst_active && dqs_c_drive); // R10
      end
      else
      begin
         dqs_c_out  = dqs_c_drive;
         dqs_c_oe_n = !burst_active;
      end
   end

   // ----------------------------------------
   // post-write wait after operating set point change or high-current entry, when either copy has single-ended clock
   // ----------------------------------------
   logic [1:0] pst_cnt;
   logic [1:0] next_pst_cnt;
   logic       fsp_chg;

   assign fsp_chg = mrw.valid && mrw.addr == SEM_ADDR_FSP_CTRL
                    && ((mrw.data[SEM_FSP_OP_BIT] != osel)
                        || (mrw.data[SEM_FSP_VRCG_BIT] && !fsp_ctrl[SEM_FSP_VRCG_BIT]));

   always_comb
   begin
      next_pst_cnt = pst_cnt;
      if (fsp_chg && se_ck_any)
         next_pst_cnt = 2'(SEM_MRW_PST_NCK); // R16
      else if (pst_cnt != 2'h0)
         next_pst_cnt = pst_cnt - 2'h1;
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         pst_cnt <= 2'h0;
      else
         pst_cnt <= next_pst_cnt;
   end

   assign mrw_pst_busy = pst_cnt != 2'h0;

endmodule

/* File: rtl/sem_pkg.sv */
// Purpose: shared constants and carriers for the single-ended clock/strobe mode block
// Assumes: mode register writes arrive already decoded as address and 8-bit opcode
// Notes:   mode register addresses are those of the device's mode register space
package sem_pkg;

   // ----------------------------------------
   // mode register addresses
   // ----------------------------------------
   localparam logic [5:0] SEM_ADDR_CAPABILITY = 6'h00;
   localparam logic [5:0] SEM_ADDR_CA_VREF    = 6'h0c;
   localparam logic [5:0] SEM_ADDR_FSP_CTRL   = 6'h0d;
   localparam logic [5:0] SEM_ADDR_DQ_VREF    = 6'h0e;
   localparam logic [5:0] SEM_ADDR_SE_CTRL    = 6'h33;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int SEM_CAP_SE_BIT      = 5;
   localparam int SEM_SE_RD_BIT       = 1;
   localparam int SEM_SE_WR_BIT       = 2;
   localparam int SEM_SE_CK_BIT       = 3;
   localparam int SEM_FSP_OP_BIT      = 7;
   localparam int SEM_FSP_WR_BIT      = 6;
   localparam int SEM_FSP_VRCG_BIT    = 3;
   localparam int SEM_FSP_RPT_BIT     = 1;

   // ----------------------------------------
   // reset values and limits
   // ----------------------------------------
   localparam logic [7:0] SEM_SE_CTRL_RST  = 8'h00;
   localparam logic [7:0] SEM_FSP_CTRL_RST = 8'h00;
   localparam logic [7:0] SEM_CAP_RST      = 8'h00;
   localparam logic [5:0] SEM_VREF_SE_MAX  = 6'h32;
   localparam int         SEM_MRW_PST_NCK  = 2;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic       valid;
      logic [5:0] addr;
      logic [7:0] data;
   } sem_mrw_s;

   typedef struct packed {
      logic rd_se;
      logic wr_se;
      logic ck_se;
   } sem_mode_s;

   typedef enum logic [2:0] {
      SEM_CMD_WRITE,
      SEM_CMD_MASK_WRITE,
      SEM_CMD_READ,
      SEM_CMD_MRR,
      SEM_CMD_WR_FIFO,
      SEM_CMD_RD_FIFO,
      SEM_CMD_RD_DQ_CAL,
      SEM_CMD_OTHER
   } sem_cmd_e;

endpackage

/* File: tb/sem_host_model.sv */
// Purpose: host side of the complement strobe wire
// Assumes: device output enable is active low
// Notes:   released wire shows a level that flips each cycle, held high during bus training
`timescale 1ns/1ps
module sem_host_model
(
   input  wire logic clock,
   input  wire logic dqs_c_out,
   input  wire logic dqs_c_oe_n,
   input  wire logic cbt_active,
   output logic      dqs_c_pin
);
   logic host_lvl = 1'b0;
   always @(posedge clock) host_lvl <= cbt_active ? 1'b1 : !host_lvl;
   assign dqs_c_pin = dqs_c_oe_n ? host_lvl : dqs_c_out;
endmodule

/* File: tb/sem_mode_ctrl_test.sv */
// Purpose: directed test of sem_mode_ctrl
// Assumes: inputs change 10 ns after the rising edge
// Notes:   termination requests held on to expose forcing
`timescale 1ns/1ps
module sem_mode_ctrl_test;
   import sem_pkg::*;
   logic       clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
   logic       burst_active = 1'b0, dqs_c_drive = 1'b1;
   logic       cbt_active = 1'b0;
   logic       odt_ck_req = 1'b1, odt_dq_req = 1'b1;
   logic [5:0] mrr_addr = 6'h00;
   sem_mrw_s   mrw = '0;
   sem_cmd_e   cmd = SEM_CMD_OTHER;
   logic [7:0] mrr_data;
   sem_mode_s  active_mode;
   logic       rd_burst_se, wr_burst_se, dqs_c_out, dqs_c_oe_n, dqs_c_pin;
   logic       odt_ck_en, odt_dq_en, se_ck_any, mrw_pst_busy;
   int         mismatches = 0, check_count = 0;
   sem_mode_ctrl  u_sem_mode_ctrl (.*);
   sem_host_model u_sem_host_model (.*);
   initial forever #50 clock = !clock;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step;
      @(posedge clock);
      #10;
   endtask
   task automatic mr_wr(input logic [5:0] a, input logic [7:0] d);
      step;
      mrw = '{1'b1, a, d};
      step;
      mrw.valid = 1'b0;
   endtask
   task automatic mr_rd(input logic [5:0] a, input logic [7:0] exp);
      step;
      mrr_addr = a;
      step;
      chk(mrr_data, exp);
   endtask
   task automatic issue(input sem_cmd_e c);
      step;
      cmd_valid = 1'b1;
      cmd = c;
      step;
      cmd_valid = 1'b0;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      #100000;
      mismatches++;
      test_done;
   end
   initial
   begin
      repeat (20) @(posedge clock);
      #10 rst_n = 1'b1;
      mr_rd(SEM_ADDR_CAPABILITY, 8'h20);
      mr_rd(SEM_ADDR_SE_CTRL, SEM_SE_CTRL_RST);
      mr_rd(6'h3f, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         mr_wr(SEM_ADDR_FSP_CTRL, 8'h40);
         repeat (2) step;
         mr_wr(SEM_ADDR_SE_CTRL, {4'hf, i[2:0], 1'b1});
         mr_rd(SEM_ADDR_SE_CTRL, {4'h0, i[2:0], 1'b0});
         mr_wr(SEM_ADDR_FSP_CTRL, 8'h80);
         repeat (2) step;
         chk({5'h0, active_mode}, {5'h0, i[0], i[1], i[2]});
         chk({6'h0, odt_ck_en, odt_dq_en}, {6'h0, !i[2], !i[1]});
      end
      $display("test combinations done");
      odt_ck_req = 1'b0;
      odt_dq_req = 1'b0;
      mr_wr(SEM_ADDR_FSP_CTRL, 8'h40);
      repeat (2) step;
      mr_wr(SEM_ADDR_SE_CTRL, 8'h00);
      chk({4'h0, active_mode, se_ck_any}, 8'h00);
      mr_wr(SEM_ADDR_FSP_CTRL, 8'h80);
      chk({7'h0, mrw_pst_busy}, 8'h00);
      mr_wr(SEM_ADDR_FSP_CTRL, 8'h40);
      mr_wr(SEM_ADDR_SE_CTRL, 8'h0e);
      chk({4'h0, active_mode, se_ck_any}, 8'h09);
      mr_wr(SEM_ADDR_FSP_CTRL, 8'h80);
      chk({7'h0, mrw_pst_busy}, 8'h01);
      step;
      chk({7'h0, mrw_pst_busy}, 8'h01);
      step;
      chk({4'h0, active_mode, mrw_pst_busy}, 8'h0e);
      mr_wr(SEM_ADDR_FSP_CTRL, 8'h88);
      chk({7'h0, mrw_pst_busy}, 8'h01);
      repeat (2) step;
      chk({7'h0, mrw_pst_busy}, 8'h00);
      mr_wr(SEM_ADDR_FSP_CTRL, 8'h80);
      chk({7'h0, mrw_pst_busy}, 8'h00);
      mr_wr(SEM_ADDR_CA_VREF, {2'b00, SEM_VREF_SE_MAX});
      mr_wr(SEM_ADDR_DQ_VREF, {2'b01, SEM_VREF_SE_MAX});
      chk({4'h0, active_mode, mrw_pst_busy}, 8'h0e);
      $display("test set point done");
      burst_active = 1'b1;
      issue(SEM_CMD_READ);
      chk({6'h0, rd_burst_se, dqs_c_pin}, 8'h02);
      mr_wr(SEM_ADDR_SE_CTRL, 8'h0c);
      chk({7'h0, rd_burst_se}, 8'h01);
      mr_rd(SEM_ADDR_SE_CTRL, 8'h0c);
      mr_wr(SEM_ADDR_FSP_CTRL, 8'h82);
      issue(SEM_CMD_RD_DQ_CAL);
      issue(SEM_CMD_MASK_WRITE);
      chk({5'h0, rd_burst_se, wr_burst_se, dqs_c_pin}, 8'h03);
      mr_wr(SEM_ADDR_SE_CTRL, 8'h02);
      issue(SEM_CMD_MRR);
      mr_wr(SEM_ADDR_SE_CTRL, 8'h00);
      issue(SEM_CMD_OTHER);
      chk({7'h0, rd_burst_se}, 8'h01);
      issue(SEM_CMD_RD_FIFO);
      issue(SEM_CMD_WRITE);
      issue(SEM_CMD_WR_FIFO);
      chk({6'h0, rd_burst_se, wr_burst_se}, 8'h01);
      burst_active = 1'b0;
      cbt_active = 1'b1;
      step;
      chk({6'h0, dqs_c_oe_n, dqs_c_pin}, 8'h03);
      cbt_active = 1'b0;
      $display("test burst done");
      test_done;
   end
endmodule

/* File: tb/sem_mode_monitor.sv */
// Purpose: port checker for sem_mode_ctrl
// Assumes: one clock, async active-low reset
// Notes:   bound after the module
`timescale 1ns/1ps
module sem_mode_monitor
   import sem_pkg::*;
#(parameter bit SE_SUPPORTED = 1'b1)
(
   input wire logic       clock,
   input wire logic       rst_n,
   input wire sem_mrw_s   mrw,
   input wire logic [5:0] mrr_addr,
   input wire logic       cmd_valid,
   input wire sem_cmd_e   cmd,
   input wire logic [7:0] mrr_data,
   input wire sem_mode_s  active_mode,
   input wire logic       rd_burst_se,
   input wire logic       dqs_c_out,
   input wire logic       dqs_c_oe_n,
   input wire logic       odt_ck_en,
   input wire logic       odt_dq_en,
   input wire logic       mrw_pst_busy
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_cap_report: assert property (
      mrr_addr == 6'h00 |=> mrr_data == {2'h0, SE_SUPPORTED, 5'h00}) else $error("cap bit");
   a_ck_term_off: assert property (
      active_mode.ck_se |-> !odt_ck_en) else $error("clock term on");
   a_dq_term_off: assert property (
      active_mode.wr_se |-> !odt_dq_en) else $error("strobe term on");
   a_rd_latch: assert property (
      cmd_valid && cmd inside {SEM_CMD_READ, SEM_CMD_MRR, SEM_CMD_RD_FIFO, SEM_CMD_RD_DQ_CAL}
      |=> rd_burst_se == $past(active_mode.rd_se)) else $error("read mode latch");
   a_rd_hold: assert property (
      !cmd_valid |=> $stable(rd_burst_se)) else $error("read mode moved");
   a_rd_any_time: assert property (
      mrw.valid && mrw.addr == SEM_ADDR_SE_CTRL |=> active_mode.rd_se == $past(mrw.data[1]))
      else $error("read bit not applied");
   a_busy_two: assert property (
      $rose(mrw_pst_busy) |-> mrw_pst_busy [*2] ##1 !mrw_pst_busy) else $error("busy length");
   a_se_rd_low: assert property (
      rd_burst_se && !dqs_c_oe_n |-> !dqs_c_out) else $error("complement high");
   cover property (cmd_valid && cmd == SEM_CMD_RD_DQ_CAL);
   cover property ($rose(mrw_pst_busy));
   cover property (rd_burst_se && !dqs_c_oe_n);
endmodule

bind sem_mode_ctrl sem_mode_monitor #(.SE_SUPPORTED(SE_SUPPORTED)) u_sem_mode_monitor (.*);
